/* File: ram_debug_readout.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ram_readout_consts.svh"

module ram_debug_readout
  import ram_readout_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire sysreg_enc_type req_enc_i,
  input wire logic [1:0] current_exception_level_i,
  input wire logic [63:0] req_wdata_i,
  input wire logic ram_ready_i,
  input wire logic [63:0] ram_idata0_i,
  input wire logic [63:0] ram_idata1_i,
  input wire logic [63:0] ram_idata2_i,
  input wire logic [63:0] ram_ddata0_i,
  input wire logic [63:0] ram_ddata1_i,
  input wire logic [63:0] ram_ddata2_i,
  output logic ram_req_o,
  output logic [7:0] ram_identifier_field_o,
  output logic [23:0] ram_index_o,
  output logic busy_o,
  output logic resp_valid_o,
  output resp_type resp_o,
  output logic [63:0] resp_rdata_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT
  } state_type;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // async assert, sync release: no flop leaves reset on a runt edge
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic is_select;
  logic is_instr_rd;
  logic is_data_rd;
  logic at_top_level;
  logic word_sel_ok;

  assign at_top_level = (current_exception_level_i == `HIGHEST_EL);
  // op2 codes above 2 fall through to the undefined answer
  assign word_sel_ok = (req_enc_i.op2 == `OP2_WORD0) ||
                       (req_enc_i.op2 == `OP2_WORD1) ||
                       (req_enc_i.op2 == `OP2_WORD2);
  assign is_select = req_write_i &&
                     req_enc_i.op0 == `OP0_SYS_INSTR &&
                     req_enc_i.op1 == `OP1_READOUT &&
                     req_enc_i.crn == `CRN_READOUT &&
                     req_enc_i.crm == `CRM_SELECT &&
                     req_enc_i.op2 == `OP2_SELECT;
  assign is_instr_rd = !req_write_i &&
                       req_enc_i.op0 == `OP0_SYS_REG &&
                       req_enc_i.op1 == `OP1_READOUT &&
                       req_enc_i.crn == `CRN_READOUT &&
                       req_enc_i.crm == `CRM_INSTR_SIDE &&
                       word_sel_ok;
  assign is_data_rd = !req_write_i &&
                      req_enc_i.op0 == `OP0_SYS_REG &&
                      req_enc_i.op1 == `OP1_READOUT &&
                      req_enc_i.crn == `CRN_READOUT &&
                      req_enc_i.crm == `CRM_DATA_SIDE &&
                      word_sel_ok;

  // ----------------------------------------------------------------
  // ram answer, grouped per side
  // ----------------------------------------------------------------
  readout_set_type instr_set;
  readout_set_type data_set;

  always_comb
  begin
    instr_set.d0 = ram_idata0_i;
    instr_set.d1 = ram_idata1_i;
    instr_set.d2 = ram_idata2_i;
    data_set.d0 = ram_ddata0_i;
    data_set.d1 = ram_ddata1_i;
    data_set.d2 = ram_ddata2_i;
  end

  // ----------------------------------------------------------------
  // readout banks
  // ----------------------------------------------------------------
  // both banks load together: all six words come from one select
  logic bank_load;
  logic [63:0] instr_word;
  logic [63:0] data_word;

  readout_bank #(
    .WIDTH(64)
  ) u_instr_bank (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_ff),
    .load_i(bank_load),
    .w0_i(instr_set.d0),
    .w1_i(instr_set.d1),
    .w2_i(instr_set.d2),
    .sel_i(req_enc_i.op2[1:0]),
    .word_o(instr_word)
  );

  readout_bank #(
    .WIDTH(64)
  ) u_data_bank (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_ff),
    .load_i(bank_load),
    .w0_i(data_set.d0),
    .w1_i(data_set.d1),
    .w2_i(data_set.d2),
    .sel_i(req_enc_i.op2[1:0]),
    .word_o(data_word)
  );

  // ----------------------------------------------------------------
  // control
  // ----------------------------------------------------------------
  state_type state_ff;
  state_type nxt_state;

  logic ram_req_ff;
  logic nxt_ram_req;
  logic [7:0] ram_id_ff;
  logic [7:0] nxt_ram_id;
  logic [23:0] ram_index_ff;
  logic [23:0] nxt_ram_index;

  logic resp_valid_ff;
  logic nxt_resp_valid;
  resp_type resp_ff;
  resp_type nxt_resp;
  logic [63:0] rdata_ff;
  logic [63:0] nxt_rdata;

  // requests arriving while busy are not taken; caller must wait
  always_comb
  begin
    nxt_state = state_ff;
    nxt_ram_req = 1'b0;
    nxt_ram_id = ram_id_ff;
    nxt_ram_index = ram_index_ff;
    nxt_resp_valid = 1'b0;
    nxt_resp = RESP_NONE;
    nxt_rdata = 64'h0000000000000000;
    bank_load = 1'b0;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (req_valid_i)
        begin
          nxt_resp_valid = 1'b1;
          if ((is_select || is_instr_rd || is_data_rd) && !at_top_level)
          begin
            nxt_resp = RESP_UNDEF;
          end
          else if (is_select)
          begin
            // reserved upper bits ignored on purpose
            nxt_ram_id = req_wdata_i[`RAM_ID_MSB:`RAM_ID_LSB];
            nxt_ram_index =
              req_wdata_i[`RAM_INDEX_MSB:`RAM_INDEX_LSB];
            nxt_ram_req = 1'b1;
            nxt_resp_valid = 1'b0;
            nxt_state = ST_WAIT;
          end
          else if (is_instr_rd)
          begin
            nxt_resp = RESP_OK;
            nxt_rdata = instr_word;
          end
          else if (is_data_rd)
          begin
            nxt_resp = RESP_OK;
            nxt_rdata = data_word;
          end
          else
          begin
            // writes to readout registers and unknown encodings
            nxt_resp = RESP_UNDEF;
          end
        end
      end
      ST_WAIT:
      begin
        // data taken on the ready edge only; array latency is free
        nxt_ram_req = !ram_ready_i;
        if (ram_ready_i)
        begin
          bank_load = 1'b1;
          nxt_resp_valid = 1'b1;
          nxt_resp = RESP_OK;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        // stray state code: back to idle
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      state_ff <= ST_IDLE;
      ram_req_ff <= 1'b0;
      ram_id_ff <= 8'h00;
      ram_index_ff <= 24'h000000;
      resp_valid_ff <= 1'b0;
      resp_ff <= RESP_NONE;
      rdata_ff <= 64'h0000000000000000;
    end
    else
    begin
      state_ff <= nxt_state;
      ram_req_ff <= nxt_ram_req;
      ram_id_ff <= nxt_ram_id;
      ram_index_ff <= nxt_ram_index;
      resp_valid_ff <= nxt_resp_valid;
      resp_ff <= nxt_resp;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // busy flag
  // ----------------------------------------------------------------
  // registered copy of the wait state, so busy_o has no gate on it
  logic busy_ff;
  logic nxt_busy;

  always_comb
  begin
    nxt_busy = (nxt_state == ST_WAIT);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      busy_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= nxt_busy;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ram_req_o = ram_req_ff;
  assign ram_identifier_field_o = ram_id_ff;
  assign ram_index_o = ram_index_ff;
  assign busy_o = busy_ff;
  assign resp_valid_o = resp_valid_ff;
  assign resp_o = resp_ff;
  assign resp_rdata_o = rdata_ff;

endmodule
`default_nettype wire

/* File: ram_readout_consts.svh */
`ifndef RAM_READOUT_CONSTS_SVH
`define RAM_READOUT_CONSTS_SVH

// ----------------------------------------------------------------
// system instruction / register encodings
// ----------------------------------------------------------------
`define OP0_SYS_INSTR 2'h1
`define OP0_SYS_REG 2'h3
`define OP1_READOUT 3'h6
`define CRN_READOUT 4'hF
`define CRM_SELECT 4'h0
`define CRM_INSTR_SIDE 4'h0
`define CRM_DATA_SIDE 4'h1
`define OP2_SELECT 3'h0
`define OP2_WORD0 3'h0
`define OP2_WORD1 3'h1
`define OP2_WORD2 3'h2

// ----------------------------------------------------------------
// operand fields and levels
// ----------------------------------------------------------------
`define RAM_ID_MSB 31
`define RAM_ID_LSB 24
`define RAM_INDEX_MSB 23
`define RAM_INDEX_LSB 0
`define RESERVED_MSB 63
`define RESERVED_LSB 32
`define HIGHEST_EL 2'h3
`define READOUT_RESET 64'h0000000000000000

`endif

/* File: ram_readout_pkg.sv */
package ram_readout_pkg;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } sysreg_enc_type;

  typedef struct packed {
    logic [63:0] d0;
    logic [63:0] d1;
    logic [63:0] d2;
  } readout_set_type;

  typedef enum logic [1:0] {
    RESP_OK,
    RESP_UNDEF,
    RESP_NONE
  } resp_type;

endpackage

/* File: readout_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ram_readout_consts.svh"

module readout_bank
  import ram_readout_pkg::*;
#(
  parameter int WIDTH = 64
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] w0_i,
  input wire logic [WIDTH-1:0] w1_i,
  input wire logic [WIDTH-1:0] w2_i,
  input wire logic [1:0] sel_i,
  output logic [WIDTH-1:0] word_o
);

  logic [WIDTH-1:0] w0_ff;
  logic [WIDTH-1:0] w1_ff;
  logic [WIDTH-1:0] w2_ff;
  logic [WIDTH-1:0] nxt_w0;
  logic [WIDTH-1:0] nxt_w1;
  logic [WIDTH-1:0] nxt_w2;

  // ----------------------------------------------------------------
  // capture only on a completed select
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_w0 = w0_ff;
    nxt_w1 = w1_ff;
    nxt_w2 = w2_ff;
    if (load_i)
    begin
      nxt_w0 = w0_i;
      nxt_w1 = w1_i;
      nxt_w2 = w2_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      w0_ff <= WIDTH'(`READOUT_RESET);
      w1_ff <= WIDTH'(`READOUT_RESET);
      w2_ff <= WIDTH'(`READOUT_RESET);
    end
    else
    begin
      w0_ff <= nxt_w0;
      w1_ff <= nxt_w1;
      w2_ff <= nxt_w2;
    end
  end

  always_comb
  begin
    unique case (sel_i)
      2'h0: word_o = w0_ff;
      2'h1: word_o = w1_ff;
      2'h2: word_o = w2_ff;
      default: word_o = '0;
    endcase
  end

endmodule
`default_nettype wire

/* File: rdo_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ram_readout_consts.svh"
module rdo_asserts
  import ram_readout_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire sysreg_enc_type req_enc_i,
  input wire logic [1:0] current_exception_level_i,
  input wire logic [63:0] req_wdata_i,
  input wire logic ram_ready_i,
  input wire logic ram_req_o,
  input wire logic [7:0] ram_identifier_field_o,
  input wire logic [23:0] ram_index_o,
  input wire logic busy_o,
  input wire logic resp_valid_o,
  input wire resp_type resp_o,
  input wire logic [63:0] resp_rdata_o
);
  // ----
  // checks
  // ----
  logic [63:0] wd_q;
  logic tk, sel, ro, top;
  assign tk = req_valid_i && !busy_o;
  assign top = current_exception_level_i == `HIGHEST_EL;
  assign sel = req_enc_i == {`OP0_SYS_INSTR, `OP1_READOUT, `CRN_READOUT,
    `CRM_SELECT, `OP2_SELECT};
  assign ro = req_enc_i.op0 == `OP0_SYS_REG && req_enc_i.op1 == `OP1_READOUT
    && req_enc_i.crn == `CRN_READOUT && req_enc_i.crm[3:1] == 3'h0
    && req_enc_i.op2 < 3'h3;
  // operand as seen at the taking edge
  always_ff @(posedge clk_sys_i)
    wd_q <= req_wdata_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  AST_SEL:
  assert property (tk && req_write_i && sel && top |=> ram_req_o && busy_o
    && ram_identifier_field_o == wd_q[31:24] && ram_index_o == wd_q[23:0])
    else $error("select not issued");
  AST_UNDEF:
  assert property (tk && !top && (req_write_i ? sel : ro) |=> resp_valid_o
    && resp_o == RESP_UNDEF && !ram_req_o) else $error("low level accepted");
  AST_WRO:
  assert property (tk && req_write_i && ro |=> resp_o == RESP_UNDEF)
    else $error("readout written");
  AST_RD:
  assert property (tk && !req_write_i && ro && top |=> resp_valid_o
    && resp_o == RESP_OK) else $error("read refused");
  AST_DONE:
  assert property (ram_req_o && ram_ready_i |=> resp_valid_o
    && resp_o == RESP_OK && !busy_o && !ram_req_o) else $error("no done");
  AST_WAIT:
  assert property (ram_req_o && !ram_ready_i |=> ram_req_o && busy_o)
    else $error("request dropped");
  AST_HOLD:
  assert property (!tk && !ram_req_o |=> $stable(ram_index_o)
    && $stable(ram_identifier_field_o)) else $error("select fields moved");
  AST_RZ:
  assert property (resp_o != RESP_OK |-> resp_rdata_o == 64'h0)
    else $error("stray read data");
endmodule
bind ram_debug_readout rdo_asserts u_rdo_asserts (.clk_sys_i, .rstn_i,
  .req_valid_i, .req_write_i, .req_enc_i, .current_exception_level_i,
  .req_wdata_i, .ram_ready_i, .ram_req_o, .ram_identifier_field_o,
  .ram_index_o, .busy_o, .resp_valid_o, .resp_o, .resp_rdata_o);
`default_nettype wire

/* File: internal_ram_debug_readout_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ram_readout_consts.svh"
module internal_ram_debug_readout_bench
  import ram_readout_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic vld = 1'b0;
  logic wr = 1'b0;
  sysreg_enc_type enc = 16'h0000;
  logic [1:0] el = 2'h3;
  logic [63:0] wd = 64'h0;
  logic rdy = 1'b0;
  logic [7:0] k = 8'h00;
  logic [63:0] rd [6];
  logic req, busy, rv;
  logic [7:0] rid;
  logic [23:0] ridx;
  resp_type rsp;
  logic [63:0] rdat;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  // ----
  // ram side
  // ----
  function automatic logic [63:0] pat(logic [7:0] s, int w);
    return {s, 8'h5A, 8'(w), 40'hF0E1D2C3B4};
  endfunction
  // inverted off the strobe so stale data cannot match
  for (genvar i = 0; i < 6; i++)
  begin : g_rd
    assign rd[i] = rdy ? pat(k, i) : ~pat(k, i);
  end
  ram_debug_readout u_ram_debug_readout (.clk_sys_i, .rstn_i,
    .req_valid_i(vld), .req_write_i(wr), .req_enc_i(enc),
    .current_exception_level_i(el), .req_wdata_i(wd), .ram_ready_i(rdy),
    .ram_idata0_i(rd[0]), .ram_idata1_i(rd[1]), .ram_idata2_i(rd[2]),
    .ram_ddata0_i(rd[3]), .ram_ddata1_i(rd[4]), .ram_ddata2_i(rd[5]),
    .ram_req_o(req), .ram_identifier_field_o(rid), .ram_index_o(ridx),
    .busy_o(busy), .resp_valid_o(rv), .resp_o(rsp), .resp_rdata_o(rdat));
  // ----
  // tasks
  // ----
  task automatic stop_test;
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_val(input logic [63:0] g, e, input string m);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_resp(input resp_type e, input logic [63:0] d);
    check_count++;
    if (rv !== 1'b1 || rsp !== e || rdat !== d)
    begin
      failures++;
      $display("wrong value at %0t: response", $time);
    end
  endtask
  function automatic sysreg_enc_type mk(logic [1:0] o, logic [3:0] c,
    logic [2:0] p);
    return {o, `OP1_READOUT, `CRN_READOUT, c, p};
  endfunction
  // strobe left high so reads can run back to back
  task automatic op(input logic w, input sysreg_enc_type e,
    input logic [1:0] l, input logic [63:0] d);
    wr = w;
    enc = e;
    el = l;
    wd = d;
    vld = 1'b1;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic rdreg(input int i, input logic [1:0] l, input resp_type e,
    input logic [63:0] d);
    op(1'b0, mk(`OP0_SYS_REG, 4'(i / 3), 3'(i % 3)), l, 64'h0);
    chk_resp(e, d);
  endtask
  task automatic sel(input logic [1:0] l, input logic [63:0] d, input int st);
    op(1'b1, mk(`OP0_SYS_INSTR, `CRM_SELECT, `OP2_SELECT), l, d);
    if (l == `HIGHEST_EL)
    begin
      vld = 1'b0;
      chk_val(64'(req), 64'h1, "ram request");
      chk_val(64'(busy), 64'h1, "busy");
      repeat (st) @(posedge clk_sys_i);
      #1 rdy = 1'b1;
      @(posedge clk_sys_i);
      #1 rdy = 1'b0;
      chk_val(64'({req, busy}), 64'h0, "select done");
    end
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      stop_test;
    end
  end
  // ----
  // tests
  // ----
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    for (int i = 0; i < 6; i++) rdreg(i, 2'h3, RESP_OK, 64'h0);
    k = 8'h01;
    sel(2'h3, 64'h00000000A5123456, 3);
    chk_resp(RESP_OK, 64'h0);
    chk_val(64'(rid), 64'hA5, "ram select");
    chk_val(64'(ridx), 64'h123456, "entry index");
    for (int i = 0; i < 6; i++) rdreg(i, 2'h3, RESP_OK, pat(1, i));
    k = 8'h02;
    for (int l = 0; l < 3; l++)
    begin
      sel(2'(l), 64'h0000000001000001, 1);
      chk_resp(RESP_UNDEF, 64'h0);
      rdreg(5, 2'(l), RESP_UNDEF, 64'h0);
    end
    op(1'b1, mk(`OP0_SYS_REG, 4'h0, 3'h1), 2'h3, 64'h1);
    chk_resp(RESP_UNDEF, 64'h0);
    op(1'b0, mk(`OP0_SYS_REG, 4'h2, 3'h0), 2'h3, 64'h0);
    chk_resp(RESP_UNDEF, 64'h0);
    chk_val(64'(ridx), 64'h123456, "index kept");
    for (int i = 0; i < 6; i++) rdreg(i, 2'h3, RESP_OK, pat(1, i));
    k = 8'h03;
    sel(2'h3, 64'h00000000FFFFFFFF, 1);
    chk_resp(RESP_OK, 64'h0);
    chk_val(64'(ridx), 64'hFFFFFF, "index top");
    chk_val(64'(rid), 64'hFF, "id top");
    for (int i = 0; i < 6; i++) rdreg(i, 2'h3, RESP_OK, pat(3, i));
    vld = 1'b0;
    stop_test;
  end
endmodule
`default_nettype wire
